/* File: logic/nvcp_programmer.sv */
/*
 * Configuration cell programmer: staging bytes, CRC confirmation,
 * burn control, status register and pin driven factory restore.
 * Assumes a decoded register port on clk_sys_i; pins are asynchronous.
 */
// Summary of operation
// - After any reset event, forced normal follows the cells' forced normal default bit.
// - A matching CRC starts the burn only in forced normal with status bit 0 set; a mismatch aborts without touching cells.
// - A successful burn ends with a system reset pulse.
// - Cell contents read as zero while the burn runs.
// - After programming, staging writes are blocked until presets are restored.
// - Status bit 0 is one when cells may be reprogrammed; preset one.
// - Status bits 7:2 count reprograms and saturate at all ones.
// - A factory restore also increments the saturating counter.
// - The counter never gates programming.
// - Status bit 1 shows a corrected single-bit cell error.
// - A multi-bit cell error suppresses the restart after reprogramming.
// - CRC is 8 bits, polynomial 0x2F, MSB first over both bytes.
// - CRC starts at 0xFF, no reflection, result inverted with 0xFF.
// - Lower staging byte is processed first, then the upper one.
// - After restore, a system reset follows and forced normal mode is entered.
// - Receive pin is high during restore, then follows the clamped bus.
// - Power-on flag sets when the device leaves off mode.
`timescale 1ns/1ns
module nvcp_programmer #(
    parameter int RESTORE_TIME_US = 100
) (
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    input  wire nvcp_pkg::nvcp_reg_req_t reg_req_i,
    input  wire logic                 reset_pin_n_i,
    input  wire logic                 canh_at_bat_i,
    input  wire logic                 canl_at_gnd_i,
    input  wire logic                 bus_dominant_i,
    input  wire logic                 power_up_i,
    output logic [7:0]                rdata_o,
    output logic                      rvalid_o,
    output logic                      forced_normal_o,
    output logic                      sys_reset_o,
    output logic                      receive_data_pin_o,
    output logic                      power_on_flag_o,
    output logic                      burn_busy_o
);
    import nvcp_pkg::*;

    localparam int RESTORE_CYCLES = (RESTORE_TIME_US * 1000 + NVCP_CLK_PERIOD_NS - 1) / NVCP_CLK_PERIOD_NS;

    typedef enum logic [1:0] {NVCP_IDLE, NVCP_BURN, NVCP_RESTORE} nvcp_state_t;

    nvcp_state_t state_q;
    nvcp_cfg_t   stage_q;
    nvcp_cfg_t   cells;
    logic [7:0]  crc_confirm_value_q;
    logic [3:0]  s1_q;
    logic [3:0]  s2_q;
    logic        pwr_prev_q;
    logic [31:0] hold_q;
    logic        rxd_hold_q;
    logic        burn_go;
    logic        restore_go;
    logic        busy;
    logic        done;
    logic        single;
    logic        multi;
    logic        nvm_ready_flag;
    logic [5:0]  program_count;
    logic        crc_ok;
    logic        wr_crc;
    logic        rst_pin_low;
    logic        restore_cond;

    // ====================================================================
    // CRC over the staged bytes.
    function automatic logic [7:0] nvcp_crc8(input nvcp_cfg_t c);
        logic [7:0] crc;
        crc = NVCP_CRC_INIT;
        for (int i = 0; i < 2; i++) begin
            crc = crc ^ (i == 0 ? c.startup : c.devcfg);
            for (int j = 0; j < 8; j++) begin
                crc = crc[7] ? ((crc << 1) ^ NVCP_CRC_POLY) : (crc << 1);
            end
        end
        return crc ^ NVCP_CRC_XOR;
    endfunction : nvcp_crc8

    // ====================================================================
    // Pin synchronisers; only the second stage is read by logic.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s1_q       <= 4'h1;
            s2_q       <= 4'h1;
            pwr_prev_q <= 1'b0;
        end else begin
            s1_q       <= {bus_dominant_i, power_up_i, canh_at_bat_i & canl_at_gnd_i, reset_pin_n_i};
            s2_q       <= s1_q;
            pwr_prev_q <= s2_q[2];
        end
    end

    assign rst_pin_low  = !s2_q[0];
    assign restore_cond = s2_q[2] && rst_pin_low && s2_q[1];

    // ====================================================================
    // Cell array.
    nvcp_cell_array u_cells (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .burn_i    (burn_go),
        .restore_i (restore_go),
        .wdata_i   (stage_q),
        .busy_o    (busy),
        .done_o    (done),
        .cfg_o     (cells),
        .single_o  (single),
        .multi_o   (multi),
        .ready_o   (nvm_ready_flag),
        .count_o   (program_count)
    );

    // The counter is deliberately absent from this start condition.
    assign wr_crc     = reg_req_i.wr && reg_req_i.addr == NVCP_ADDR_CRC;
    assign crc_ok     = reg_req_i.wdata == nvcp_crc8(stage_q);
    assign burn_go    = state_q == NVCP_IDLE && wr_crc && crc_ok && forced_normal_o && nvm_ready_flag;
    assign restore_go = state_q == NVCP_IDLE && restore_cond && hold_q == 32'(RESTORE_CYCLES - 1);

    // ====================================================================
    // Control sequence.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= NVCP_IDLE;
        end else begin
            case (state_q)
                NVCP_IDLE: begin
                    if (burn_go) state_q <= NVCP_BURN;
                    else if (restore_go) state_q <= NVCP_RESTORE;
                end
                NVCP_BURN, NVCP_RESTORE: begin
                    if (done) state_q <= NVCP_IDLE;
                end
                default: state_q <= NVCP_IDLE;
            endcase
        end
    end

    // Restore qualification time counts only while all conditions hold.
    // The count parks one past its trigger, so one power-up restores only once.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            hold_q <= 32'h0000_0000;
        end else if (!restore_cond) begin
            hold_q <= 32'h0000_0000;
        end else if (state_q == NVCP_IDLE && hold_q != 32'(RESTORE_CYCLES)) begin
            hold_q <= hold_q + 32'h0000_0001;
        end
    end

    // Restart is withheld on a double error after a burn so a bad part stays visible.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sys_reset_o <= 1'b0;
        end else begin
            sys_reset_o <= done && !(state_q == NVCP_BURN && multi);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            forced_normal_o <= 1'b1;
        end else if (sys_reset_o || rst_pin_low) begin
            forced_normal_o <= cells.devcfg[NVCP_FORCED_NORMAL_DEFAULT_BIT];
        end
    end

    // ====================================================================
    // Staging and confirmation registers.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            stage_q <= {NVCP_PRESET_DEVCFG, NVCP_PRESET_STARTUP};
        end else if (done) begin
            stage_q <= cells;
        end else if (reg_req_i.wr && nvm_ready_flag && state_q == NVCP_IDLE) begin
            if (reg_req_i.addr == NVCP_ADDR_STARTUP) stage_q.startup <= reg_req_i.wdata;
            if (reg_req_i.addr == NVCP_ADDR_DEVCFG) stage_q.devcfg <= reg_req_i.wdata;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            crc_confirm_value_q <= NVCP_BYTE_ZERO;
        end else if (wr_crc) begin
            crc_confirm_value_q <= reg_req_i.wdata;
        end
    end

    // ====================================================================
    // Power-on flag: set on leaving power-up, write one to clear, set wins.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            power_on_flag_o <= 1'b0;
        end else if (pwr_prev_q && !s2_q[2]) begin
            power_on_flag_o <= 1'b1;
        end else if (reg_req_i.wr && reg_req_i.addr == NVCP_ADDR_SYSEVT && reg_req_i.wdata[NVCP_PO_BIT]) begin
            power_on_flag_o <= 1'b0;
        end
    end

    // Receive pin stays high from restore start until the power-on flag sets.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rxd_hold_q <= 1'b0;
        end else if (restore_go) begin
            rxd_hold_q <= 1'b1;
        end else if (power_on_flag_o && state_q != NVCP_RESTORE) begin
            rxd_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            receive_data_pin_o <= 1'b1;
            burn_busy_o        <= 1'b0;
        end else begin
            receive_data_pin_o <= restore_go || rxd_hold_q || !s2_q[3];
            burn_busy_o        <= busy;
        end
    end

    // ====================================================================
    // Register read port, answered one cycle after the request.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rdata_o  <= NVCP_BYTE_ZERO;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= reg_req_i.rd;
            rdata_o  <= NVCP_BYTE_ZERO;
            if (reg_req_i.rd) begin
                case (reg_req_i.addr)
                    NVCP_ADDR_STATUS:  rdata_o <= {program_count, single, nvm_ready_flag};
                    NVCP_ADDR_STARTUP: rdata_o <= busy ? NVCP_BYTE_ZERO : stage_q.startup;
                    NVCP_ADDR_DEVCFG:  rdata_o <= busy ? NVCP_BYTE_ZERO : stage_q.devcfg;
                    NVCP_ADDR_CRC:     rdata_o <= crc_confirm_value_q;
                    NVCP_ADDR_SYSEVT:  rdata_o <= {3'h0, power_on_flag_o, 4'h0};
                    default:           rdata_o <= NVCP_BYTE_ZERO;
                endcase
            end
        end
    end

    // ====================================================================
    // Assertions.
    sequence s_good_confirm;
        burn_go;
    endsequence

    sequence s_burn_runs;
        state_q == NVCP_BURN && busy;
    endsequence

    burn_start_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_good_confirm |=> s_burn_runs ##1 busy)
        else $error("burn did not start after a valid confirmation");

    crc_abort_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (state_q == NVCP_IDLE && wr_crc && reg_req_i.wdata != nvcp_crc8(stage_q) && !restore_go)
        |=> state_q == NVCP_IDLE && !busy)
        else $error("wrong CRC still started a burn");

    burn_restart_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (done && state_q == NVCP_BURN && !multi) |=> sys_reset_o ##1 !sys_reset_o)
        else $error("no single reset pulse after burn");

    no_restart_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (done && state_q == NVCP_BURN && multi) |=> !sys_reset_o)
        else $error("restart despite multi-bit error");

    read_blocked_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (busy && reg_req_i.rd && reg_req_i.addr == NVCP_ADDR_STARTUP) |=> rdata_o == NVCP_BYTE_ZERO)
        else $error("cell contents returned during burn");

    stage_lock_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (!nvm_ready_flag && !done && reg_req_i.wr) |=> $stable(stage_q))
        else $error("staging written while locked");

    status_ready_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (reg_req_i.rd && reg_req_i.addr == NVCP_ADDR_STATUS)
        |=> rvalid_o && rdata_o[0] == $past(nvm_ready_flag) && rdata_o[7:2] == $past(program_count))
        else $error("status read does not match ready flag or counter");

    count_sat_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        program_count == NVCP_COUNT_MAX |=> program_count == NVCP_COUNT_MAX)
        else $error("program counter wrapped");

    count_step_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        (done && $past(program_count) != NVCP_COUNT_MAX) |-> program_count == $past(program_count) + 6'h01)
        else $error("counter did not step on completion");

    rxd_high_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        state_q == NVCP_RESTORE |-> receive_data_pin_o)
        else $error("receive pin low during restore");

    fnm_follow_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sys_reset_o |=> forced_normal_o == $past(cells.devcfg[NVCP_FORCED_NORMAL_DEFAULT_BIT]))
        else $error("forced normal does not follow cell default");
endmodule : nvcp_programmer

/* File: inc/nvcp_pkg.sv */
/*
 * Shared constants and types for the configuration cell programmer.
 * Assumes a single 100 MHz system clock and an 8-bit register port.
 */
package nvcp_pkg;
    // ====================================================================
    // Register map.
    localparam logic [6:0] NVCP_ADDR_SYSEVT  = 7'h61;
    localparam logic [6:0] NVCP_ADDR_STATUS  = 7'h70;
    localparam logic [6:0] NVCP_ADDR_STARTUP = 7'h73;
    localparam logic [6:0] NVCP_ADDR_DEVCFG  = 7'h74;
    localparam logic [6:0] NVCP_ADDR_CRC     = 7'h75;
    // ====================================================================
    // Field positions.
    localparam int NVCP_READY_BIT = 0;
    localparam int NVCP_ECC_BIT   = 1;
    localparam int NVCP_COUNT_LSB = 2;
    localparam int NVCP_FORCED_NORMAL_DEFAULT_BIT  = 3;
    localparam int NVCP_PO_BIT    = 4;
    // ====================================================================
    // Values and presets.
    localparam logic [7:0] NVCP_CRC_POLY       = 8'h2F;
    localparam logic [7:0] NVCP_CRC_INIT       = 8'hFF;
    localparam logic [7:0] NVCP_CRC_XOR        = 8'hFF;
    localparam logic [7:0] NVCP_PRESET_STARTUP = 8'h00;
    localparam logic [7:0] NVCP_PRESET_DEVCFG  = 8'h08;
    localparam logic [5:0] NVCP_COUNT_RESET    = 6'h00;
    localparam logic [5:0] NVCP_COUNT_MAX      = 6'h3F;
    localparam logic [7:0] NVCP_BYTE_ZERO      = 8'h00;
    // ====================================================================
    // Timing.
    localparam int NVCP_CLK_PERIOD_NS = 10;
    localparam int NVCP_BURN_TIME_US  = 20;
    localparam int NVCP_BURN_CYCLES   = NVCP_BURN_TIME_US * 1000 / NVCP_CLK_PERIOD_NS;
    // ====================================================================
    // Carriers.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } nvcp_reg_req_t;
    typedef struct packed {
        logic [7:0] devcfg;
        logic [7:0] startup;
    } nvcp_cfg_t;
endpackage : nvcp_pkg

/* File: logic/nvcp_cell_array.sv */
/*
 * Configuration cell array with SECDED check bits, burn timer and
 * saturating program counter.
 * Assumes burn and restore requests arrive as one-cycle pulses while idle.
 */
`timescale 1ns/1ns
module nvcp_cell_array (
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              burn_i,
    input  wire logic              restore_i,
    input  wire nvcp_pkg::nvcp_cfg_t wdata_i,
    output logic                   busy_o,
    output logic                   done_o,
    output nvcp_pkg::nvcp_cfg_t    cfg_o,
    output logic                   single_o,
    output logic                   multi_o,
    output logic                   ready_o,
    output logic [5:0]             count_o
);
    import nvcp_pkg::*;

    localparam logic [15:0] PRESET_CELLS = {NVCP_PRESET_DEVCFG, NVCP_PRESET_STARTUP};

    logic [15:0] cells_q;
    logic [4:0]  chk_q;
    logic        par_q;
    logic [15:0] pend_q;
    logic [15:0] cnt_q;
    logic        restore_q;
    logic [4:0]  syn;
    logic        perr;
    logic [15:0] fixed;

    // ====================================================================
    // Hamming syndrome; data bits sit at the non-power-of-two positions.
    function automatic logic [4:0] nvcp_syn(input logic [15:0] d);
        logic [4:0] s;
        logic [4:0] p;
        s = 5'h00;
        p = 5'h03;
        for (int k = 0; k < 16; k++) begin
            if (d[k]) s = s ^ p;
            p = p + 5'h01;
            if (p == 5'h04 || p == 5'h08 || p == 5'h10) p = p + 5'h01;
        end
        return s;
    endfunction : nvcp_syn

    always_comb begin
        logic [4:0] p;
        p     = 5'h03;
        syn   = chk_q ^ nvcp_syn(cells_q);
        perr  = (^cells_q) ^ (^chk_q) ^ par_q;
        fixed = cells_q;
        for (int k = 0; k < 16; k++) begin
            if (perr && syn == p) fixed[k] = ~cells_q[k];
            p = p + 5'h01;
            if (p == 5'h04 || p == 5'h08 || p == 5'h10) p = p + 5'h01;
        end
    end

    // ====================================================================
    // Burn timer. Reads are meaningless while it runs, so cfg_o is zeroed.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
            cnt_q     <= 16'h0000;
            pend_q    <= 16'h0000;
            restore_q <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (!busy_o && (burn_i || restore_i)) begin
                busy_o    <= 1'b1;
                cnt_q     <= 16'(NVCP_BURN_CYCLES - 1);
                restore_q <= restore_i;
                pend_q    <= restore_i ? {NVCP_PRESET_DEVCFG, NVCP_PRESET_STARTUP} : wdata_i;
            end else if (busy_o) begin
                if (cnt_q == 16'h0000) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    cnt_q <= cnt_q - 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            // Check bits must match the presets, or reset itself reads as a bit error.
            cells_q <= PRESET_CELLS;
            chk_q   <= nvcp_syn(PRESET_CELLS);
            par_q   <= (^PRESET_CELLS) ^ (^nvcp_syn(PRESET_CELLS));
            ready_o <= 1'b1;
            count_o <= NVCP_COUNT_RESET;
        end else begin
            if (busy_o && cnt_q == 16'h0000) begin
                cells_q <= pend_q;
                chk_q   <= nvcp_syn(pend_q);
                par_q   <= (^pend_q) ^ (^nvcp_syn(pend_q));
                ready_o <= restore_q;
                if (count_o != NVCP_COUNT_MAX) count_o <= count_o + 6'h01;
            end
        end
    end

    always_comb begin
        cfg_o    = busy_o ? nvcp_cfg_t'(16'h0000) : nvcp_cfg_t'(fixed);
        single_o = perr;
        multi_o  = !perr && syn != 5'h00;
    end
endmodule : nvcp_cell_array

/* File: tb/nvcp_host_model.sv */
/*
 * Pin side model for the configuration cell programmer: power-up phase,
 * factory restore pin conditions and the clamped bus level.
 * Assumes the bench steps it by levels on the system clock.
 */
`timescale 1ns/1ns
module nvcp_host_model #(
    parameter int HOLD_CYCLES = 2400
) (
    input  wire logic clk_sys_i,
    input  wire logic boot_i,
    input  wire logic restore_i,
    output logic      reset_pin_n_o,
    output logic      canh_at_bat_o,
    output logic      canl_at_gnd_o,
    output logic      bus_dominant_o,
    output logic      power_up_o
);
    // ====================================================================
    // Restore hold.
    // The hold outlasts restore plus burn, so power-up never ends mid-burn.
    logic [15:0] hold_q = 16'h0000;
    logic        in_hold;
    assign in_hold = restore_i && (hold_q < 16'(HOLD_CYCLES));
    always_ff @(posedge clk_sys_i) begin
        if (!restore_i) begin
            hold_q <= 16'h0000;
        end else if (in_hold) begin
            hold_q <= hold_q + 16'h0001;
        end
    end
    assign reset_pin_n_o  = !in_hold;
    assign canh_at_bat_o  = restore_i;
    assign canl_at_gnd_o  = restore_i;
    assign bus_dominant_o = restore_i;
    assign power_up_o     = boot_i || in_hold;
endmodule : nvcp_host_model

/* File: tb/tb.sv */
/*
 * Self-checking bench for the configuration cell programmer.
 * Assumes the decoded register port and the pin model on one clock.
 */
`timescale 1ns/1ns
module tb;
    import nvcp_pkg::*;
    logic          clk_sys_i;
    logic          rst_n_i;
    nvcp_reg_req_t req_q;
    logic          boot_q;
    logic          restore_q;
    logic          pin_rst_n, pin_canh, pin_canl, pin_dom, pin_pwr;
    logic [7:0]    rdata;
    logic          rvalid, fn, sysrst, rxd, po, busy;
    int            failures;
    int            n_tests;

    nvcp_programmer #(.RESTORE_TIME_US(1)) u_nvcp_programmer (
        .clk_sys_i          (clk_sys_i),
        .rst_n_i            (rst_n_i),
        .reg_req_i          (req_q),
        .reset_pin_n_i      (pin_rst_n),
        .canh_at_bat_i      (pin_canh),
        .canl_at_gnd_i      (pin_canl),
        .bus_dominant_i     (pin_dom),
        .power_up_i         (pin_pwr),
        .rdata_o            (rdata),
        .rvalid_o           (rvalid),
        .forced_normal_o    (fn),
        .sys_reset_o        (sysrst),
        .receive_data_pin_o (rxd),
        .power_on_flag_o    (po),
        .burn_busy_o        (busy)
    );
    nvcp_host_model u_nvcp_host_model (
        .clk_sys_i      (clk_sys_i),
        .boot_i         (boot_q),
        .restore_i      (restore_q),
        .reset_pin_n_o  (pin_rst_n),
        .canh_at_bat_o  (pin_canh),
        .canl_at_gnd_o  (pin_canl),
        .bus_dominant_o (pin_dom),
        .power_up_o     (pin_pwr)
    );

    // ====================================================================
    // Checking and register access.
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        $display("failures=%0d n_tests=%0d", failures, n_tests);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        req_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    endtask : wr
    task automatic idle();
        @(posedge clk_sys_i);
        req_q <= '0;
    endtask : idle
    // A read with no answer pulse yields unknown, so it can never match.
    task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        req_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys_i);
        req_q <= '0;
        @(negedge clk_sys_i);
        chk($sformatf("reg %h", a), (rvalid === 1'b1) ? rdata : 8'hXX, exp);
    endtask : rdc
    task automatic wait_for(input int which, input int lim);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(negedge clk_sys_i);
            case (which)
                0: hit = (busy === 1'b1);
                1: hit = (sysrst === 1'b1);
                default: hit = (po === 1'b1);
            endcase
        end
        if (!hit) begin
            failures++;
            $display("MISMATCH wait %0d expected 1 seen 0", which);
            close_out();
        end
    endtask : wait_for
    task automatic no_burn();
        idle();
        repeat (20) begin
            @(negedge clk_sys_i);
            chk("burn_busy", {7'h00, busy}, 8'h00);
        end
    endtask : no_burn
    function automatic logic [7:0] crc8(input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] c;
        c = 8'hFF;
        for (int n = 0; n < 16; n++) begin
            if (n % 8 == 0) c = c ^ ((n == 0) ? lo : hi);
            c = c[7] ? ((c << 1) ^ 8'h2F) : (c << 1);
        end
        return c ^ 8'hFF;
    endfunction : crc8
    task automatic prog(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] st);
        wr(NVCP_ADDR_STARTUP, lo);
        wr(NVCP_ADDR_DEVCFG, hi);
        wr(NVCP_ADDR_CRC, crc8(lo, hi));
        idle();
        wait_for(0, 10);
        rdc(NVCP_ADDR_STARTUP, 8'h00);
        wait_for(1, 2100);
        repeat (2) @(negedge clk_sys_i);
        chk("forced_normal", {7'h00, fn}, {7'h00, hi[3]});
        rdc(NVCP_ADDR_STATUS, st);
        wr(NVCP_ADDR_STARTUP, ~lo);
        rdc(NVCP_ADDR_STARTUP, lo);
        rdc(NVCP_ADDR_DEVCFG, hi);
    endtask : prog

    // ====================================================================
    // Main sequence.
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        rst_n_i = 1'b0;
        req_q = '0;
        boot_q = 1'b1;
        restore_q = 1'b0;
        failures = 0;
        n_tests = 0;
        repeat (20) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        // Power-up ends after reset, so the power-on flag sees its falling edge.
        repeat (4) @(posedge clk_sys_i);
        boot_q <= 1'b0;
        repeat (5) @(negedge clk_sys_i);
        chk("forced_normal", {7'h00, fn}, 8'h01);
        rdc(NVCP_ADDR_STATUS, 8'h01);
        rdc(NVCP_ADDR_DEVCFG, NVCP_PRESET_DEVCFG);
        rdc(NVCP_ADDR_SYSEVT, 8'h10);
        wr(NVCP_ADDR_SYSEVT, 8'h10);
        rdc(NVCP_ADDR_SYSEVT, 8'h00);
        // Staging byte changed after the CRC was worked out: must not burn.
        wr(NVCP_ADDR_STARTUP, 8'h3C);
        wr(NVCP_ADDR_DEVCFG, 8'h28);
        wr(NVCP_ADDR_STARTUP, 8'h3D);
        wr(NVCP_ADDR_CRC, crc8(8'h3C, 8'h28));
        no_burn();
        rdc(NVCP_ADDR_CRC, crc8(8'h3C, 8'h28));
        wr(NVCP_ADDR_STATUS, 8'hFF);
        rdc(NVCP_ADDR_STATUS, 8'h01);
        prog(8'h3C, 8'h28, 8'h04);
        wr(NVCP_ADDR_CRC, crc8(8'h3C, 8'h28));
        no_burn();
        @(posedge clk_sys_i);
        restore_q <= 1'b1;
        wait_for(0, 300);
        chk("rx_pin", {7'h00, rxd}, 8'h01);
        wait_for(1, 2100);
        repeat (2) @(negedge clk_sys_i);
        chk("forced_normal", {7'h00, fn}, 8'h01);
        wait_for(2, 600);
        repeat (4) @(negedge clk_sys_i);
        chk("rx_pin", {7'h00, rxd}, 8'h00);
        rdc(NVCP_ADDR_STATUS, 8'h09);
        rdc(NVCP_ADDR_STARTUP, NVCP_PRESET_STARTUP);
        @(posedge clk_sys_i);
        restore_q <= 1'b0;
        prog(8'h11, 8'h09, 8'h0C);
        close_out();
    end
endmodule : tb
